// ### inc/tws_pkg.sv
/*
 * Constants, register map and state type of the two-wire serial channel.
 * Assumes one 40 MHz reference clock and an 8-bit register port.
 */
// Notes on behaviour
// - words move eight bits at a time, one bit per serial clock.
// - the shift register advances on each rising serial clock edge.
// - the output latch drives the selected data pin, most significant bit first.
// - the selected data pin level is captured on each rising serial clock edge.
// - after eight bits shifting stops; with transfer end selected as source, the transfer-done flag is set.
// - data pins are open drain; the board supplies the pull-up.
// - set and clear triggers steer the output latch; not during a transfer.
// - a shift register write starts only when enabled and, with the external clock, the clock is idle high.
// - enabling the channel after the write does not start a transfer.
// - the shift register holds the real bus level seen while transmitting.
// - address match flag is one when enabled and shift and slave address registers agree.
// - with the internal clock selected, the clock pin has its own port latch for static levels.
// - clock line level flag is read only, reads pin level, zero when disabled.
// - the clear trigger clears the output latch and then reads back zero.
// - source select picks transfer end or bus release to set the done flag.
package tws_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_SHIFT = 3'h0;
    localparam logic [2:0] OFS_SLAVE = 3'h1;
    localparam logic [2:0] OFS_MODE = 3'h2;
    localparam logic [2:0] OFS_BUSCTL = 3'h3;
    localparam logic [2:0] OFS_TIMING = 3'h4;
    localparam logic [2:0] OFS_PORTS = 3'h5;
    localparam logic [2:0] OFS_STATUS = 3'h6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_ENABLE = 7;
    localparam int MODE_MATCH = 6;
    localparam int MODE_WAKEUP = 5;
    localparam int MODE_SEL_HI = 4;
    localparam int MODE_SEL_LO = 2;
    localparam int MODE_CSEL_HI = 1;
    localparam int BUSCTL_SET = 0;
    localparam int BUSCTL_CLR = 1;
    localparam int TIM_CLK_LEVEL = 6;
    localparam int TIM_SRC_SEL = 5;
    localparam int TIM_ADDR_MASK = 4;
    localparam int PORT_CLK = 0;
    localparam int PORT_DATA_A = 1;
    localparam int PORT_DATA_B = 2;
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 1;

    // ------------------------------------------------------------
    // mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_TWO_WIRE = 2'h3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_CLK_PORT = 1'b1;
    localparam logic RST_DATA_PORT = 1'b0;
    localparam logic RST_OUT_LATCH = 1'b1;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [4:0] CLK_TOGGLES = 5'h10;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int REF_CLK_MHZ = 40;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * REF_CLK_MHZ + 999) / 1000;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } tws_state_type;

endpackage : tws_pkg

// ### core/tws_sync.sv
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes the pins are asynchronous to i_ref_clk.
 */
module tws_sync #(
    parameter int WIDTH = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // ------------------------------------------------------------
    // two flip-flops, pins idle high
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else if (i_clk_en) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : tws_sync

// ### core/tws_channel.sv
/*
 * Two-wire clocked serial channel: shift register, output latch,
 * clock generation, address comparator and register port.
 * Assumes pulled-up open-drain clock and data wires outside.
 */
module tws_channel
    import tws_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_sck,
    output logic o_sck_out,
    output logic o_sck_oe,
    input wire logic i_data_bus_a,
    output logic o_data_bus_a_out,
    output logic o_data_bus_a_oe,
    input wire logic i_data_bus_b,
    output logic o_data_bus_b_out,
    output logic o_data_bus_b_oe,
    output logic o_transfer_done
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    tws_state_type state_reg;
    logic [7:0] shift_reg;
    logic [7:0] slave_reg;
    logic channel_enable_reg;
    logic wakeup_select_reg;
    logic [2:0] op_mode_reg;
    logic [1:0] clk_sel_reg;
    logic irq_source_select_reg;
    logic addr_mask_reg;
    logic clock_port_latch_reg;
    logic data_port_latch_a_reg;
    logic data_port_latch_b_reg;
    logic output_latch_reg;
    logic transfer_done_reg;
    logic [3:0] bit_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic [4:0] toggles_reg;
    logic int_sck_reg;
    logic sck_prev_reg;
    logic data_prev_reg;
    logic [7:0] rdata_reg;
    logic sck_oe_reg;
    logic data_a_oe_reg;
    logic data_b_oe_reg;
    logic [2:0] pins_sync;
    logic sck_level;
    logic bus_level;
    logic sck_fall;
    logic sck_rise;
    logic two_wire;
    logic internal_clk;
    logic start_ok;
    logic start;
    logic last_bit;
    logic bus_release;
    logic done_event;
    logic addr_match;
    logic clk_level_flag;

    function automatic logic hit(input logic [2:0] addr, input logic [2:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    tws_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_clk_en(i_clk_en),
        .i_async({i_data_bus_b, i_data_bus_a, i_sck}),
        .o_sync(pins_sync)
    );

    assign sck_level = pins_sync[0];
    assign bus_level = op_mode_reg[0] ? pins_sync[2] : pins_sync[1];
    assign sck_fall = sck_prev_reg & ~sck_level;
    assign sck_rise = ~sck_prev_reg & sck_level;
    assign two_wire = (op_mode_reg[MODE_SEL_HI-MODE_SEL_LO -: 2] == MODE_TWO_WIRE);
    assign internal_clk = clk_sel_reg[MODE_CSEL_HI];
    assign start_ok = channel_enable_reg && two_wire && (state_reg == ST_IDLE)
        && (internal_clk || sck_level);
    assign start = i_wr && hit(i_addr, OFS_SHIFT) && start_ok;
    assign last_bit = (bit_cnt_reg == BITS_PER_WORD - 4'h1);
    assign bus_release = sck_level && bus_level && !data_prev_reg && (state_reg == ST_IDLE);
    assign done_event = irq_source_select_reg ? bus_release
        : ((state_reg == ST_SHIFT) && sck_rise && last_bit);
    assign addr_match = channel_enable_reg && (addr_mask_reg ? (shift_reg[7:1] == slave_reg[7:1])
        : (shift_reg == slave_reg));
    assign clk_level_flag = channel_enable_reg & sck_level;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sck_prev_reg <= 1'b1;
            data_prev_reg <= 1'b1;
        end else if (i_clk_en) begin
            sck_prev_reg <= sck_level;
            data_prev_reg <= bus_level;
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (i_clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_SHIFT;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                ST_SHIFT: begin
                    if (!channel_enable_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (sck_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (last_bit) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // shift register and output latch
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            shift_reg <= RST_BYTE;
        end else if (i_clk_en) begin
            if (i_wr && hit(i_addr, OFS_SHIFT) && (state_reg == ST_IDLE)) begin
                shift_reg <= i_wdata;
            end else if ((state_reg == ST_SHIFT) && sck_rise) begin
                shift_reg <= {shift_reg[6:0], bus_level};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            output_latch_reg <= RST_OUT_LATCH;
        end else if (i_clk_en) begin
            if ((state_reg == ST_SHIFT) && sck_fall) begin
                output_latch_reg <= shift_reg[7];
            end else if (i_wr && hit(i_addr, OFS_BUSCTL) && (state_reg == ST_IDLE)) begin
                if (i_wdata[BUSCTL_CLR]) begin
                    output_latch_reg <= 1'b0;
                end else if (i_wdata[BUSCTL_SET]) begin
                    output_latch_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // internal serial clock
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            int_sck_reg <= 1'b1;
            div_cnt_reg <= 16'h0000;
            toggles_reg <= 5'h00;
        end else if (i_clk_en) begin
            if (start) begin
                div_cnt_reg <= 16'h0000;
                toggles_reg <= 5'h00;
            end else if ((state_reg == ST_SHIFT) && internal_clk && (toggles_reg < CLK_TOGGLES)) begin
                if (div_cnt_reg == 16'(HALF_CYC - 1)) begin
                    div_cnt_reg <= 16'h0000;
                    int_sck_reg <= ~int_sck_reg;
                    toggles_reg <= toggles_reg + 5'h01;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 16'h0001;
                end
            end else if (state_reg == ST_IDLE) begin
                int_sck_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // done flag, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            transfer_done_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (done_event) begin
                transfer_done_reg <= 1'b1;
            end else if (i_wr && hit(i_addr, OFS_STATUS) && i_wdata[STAT_DONE]) begin
                transfer_done_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            slave_reg <= RST_BYTE;
            channel_enable_reg <= 1'b0;
            wakeup_select_reg <= 1'b0;
            op_mode_reg <= 3'h0;
            clk_sel_reg <= 2'h0;
            irq_source_select_reg <= 1'b0;
            addr_mask_reg <= 1'b0;
        end else if (i_clk_en && i_wr) begin
            if (hit(i_addr, OFS_SLAVE)) begin
                slave_reg <= i_wdata;
            end
            if (hit(i_addr, OFS_MODE)) begin
                channel_enable_reg <= i_wdata[MODE_ENABLE];
                wakeup_select_reg <= i_wdata[MODE_WAKEUP];
                op_mode_reg <= i_wdata[MODE_SEL_HI:MODE_SEL_LO];
                clk_sel_reg <= i_wdata[MODE_CSEL_HI:0];
            end
            if (hit(i_addr, OFS_TIMING)) begin
                irq_source_select_reg <= i_wdata[TIM_SRC_SEL];
                addr_mask_reg <= i_wdata[TIM_ADDR_MASK];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            clock_port_latch_reg <= RST_CLK_PORT;
            data_port_latch_a_reg <= RST_DATA_PORT;
            data_port_latch_b_reg <= RST_DATA_PORT;
        end else if (i_clk_en && i_wr && hit(i_addr, OFS_PORTS)) begin
            clock_port_latch_reg <= i_wdata[PORT_CLK];
            data_port_latch_a_reg <= i_wdata[PORT_DATA_A];
            data_port_latch_b_reg <= i_wdata[PORT_DATA_B];
        end
    end

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_reg <= RST_BYTE;
        end else if (i_clk_en) begin
            rdata_reg <= RST_BYTE;
            if (i_rd) begin
                case (i_addr)
                    OFS_SHIFT: rdata_reg <= shift_reg;
                    OFS_SLAVE: rdata_reg <= slave_reg;
                    OFS_MODE: rdata_reg <= {channel_enable_reg, addr_match, wakeup_select_reg,
                        op_mode_reg, clk_sel_reg};
                    OFS_TIMING: rdata_reg <= {1'b0, clk_level_flag, irq_source_select_reg,
                        addr_mask_reg, 4'h0};
                    OFS_PORTS: rdata_reg <= {5'h00, data_port_latch_b_reg, data_port_latch_a_reg,
                        clock_port_latch_reg};
                    OFS_STATUS: rdata_reg <= {6'h00, (state_reg == ST_SHIFT), transfer_done_reg};
                    default: rdata_reg <= RST_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // open-drain pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sck_oe_reg <= 1'b0;
            data_a_oe_reg <= 1'b0;
            data_b_oe_reg <= 1'b0;
        end else if (i_clk_en) begin
            sck_oe_reg <= channel_enable_reg && internal_clk
                && !(int_sck_reg && clock_port_latch_reg);
            data_a_oe_reg <= channel_enable_reg && two_wire && !op_mode_reg[0]
                && !(output_latch_reg || data_port_latch_a_reg);
            data_b_oe_reg <= channel_enable_reg && two_wire && op_mode_reg[0]
                && !(output_latch_reg || data_port_latch_b_reg);
        end
    end

    assign o_rdata = rdata_reg;
    assign o_sck_out = 1'b0;
    assign o_sck_oe = sck_oe_reg;
    assign o_data_bus_a_out = 1'b0;
    assign o_data_bus_a_oe = data_a_oe_reg;
    assign o_data_bus_b_out = 1'b0;
    assign o_data_bus_b_oe = data_b_oe_reg;
    assign o_transfer_done = transfer_done_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_start_clears_count:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && start) |=> (state_reg == ST_SHIFT) && (bit_cnt_reg == 4'h0))
    else $error("start did not enter shift with zero count");

    a_late_enable_idle:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && i_wr && hit(i_addr, OFS_SHIFT) && !channel_enable_reg && state_reg == ST_IDLE)
        |=> (state_reg == ST_IDLE))
    else $error("transfer began while channel disabled");

    a_eighth_bit_done:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && state_reg == ST_SHIFT && channel_enable_reg && sck_rise && last_bit
        && !irq_source_select_reg) |=> (state_reg == ST_IDLE) && transfer_done_reg && (bit_cnt_reg == 4'h8))
    else $error("eighth bit did not end the word");

    a_fall_drives_msb:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && state_reg == ST_SHIFT && sck_fall) |=> (output_latch_reg == $past(shift_reg[7])))
    else $error("output latch missed the leading bit");

    a_rise_captures_bus:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && state_reg == ST_SHIFT && sck_rise)
        |=> (shift_reg == {$past(shift_reg[6:0]), $past(bus_level)}))
    else $error("bus level not shifted in");

    a_clear_trigger:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && state_reg == ST_IDLE && i_wr && hit(i_addr, OFS_BUSCTL) && i_wdata[BUSCTL_CLR])
        |=> !output_latch_reg ##1 (!$past(i_clk_en) || data_a_oe_reg == ($past(channel_enable_reg && two_wire
        && !op_mode_reg[0] && !data_port_latch_a_reg))))
    else $error("clear trigger left output latch set");

    a_match_flag:
    assert property (@(posedge i_ref_clk) disable iff (i_srst) (i_clk_en && i_rd && hit(i_addr, OFS_MODE)
        && !addr_mask_reg) |=> (o_rdata[MODE_MATCH] == $past(channel_enable_reg && shift_reg == slave_reg)))
    else $error("address match flag wrong");

    a_level_when_off:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && i_rd && hit(i_addr, OFS_TIMING) && !channel_enable_reg)
        |=> !o_rdata[TIM_CLK_LEVEL] && (o_rdata[3:0] == 4'h0))
    else $error("clock level flag not forced low");

    a_data_pin_released:
    assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_clk_en && channel_enable_reg && two_wire && !op_mode_reg[0] && output_latch_reg)
        |=> !o_data_bus_a_oe)
    else $error("data pin pulled low with latch high");

endmodule : tws_channel

// ### bench/tws_far_model.sv
/* Far-side bus device: makes framed external clocks, drives and hears data.
 * Assumes the bench resolves the pulled-up open-drain wires. */
module tws_far_model (
    input wire logic i_sck,
    input wire logic i_data,
    input wire logic i_jam,
    output logic o_sck_oe,
    output logic o_data_oe,
    output logic [7:0] o_rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic frame_oe;
    // ------------------------------------------------------------
    // frame driver and listener
    // ------------------------------------------------------------
    initial begin
        o_sck_oe = 1'b0;
        frame_oe = 1'b0;
        o_rx_byte = 8'h00;
    end
    // pulls low only, never drives high
    assign o_data_oe = frame_oe | i_jam;
    // samples on rising clock, msb first
    always @(posedge i_sck) begin
        o_rx_byte <= {o_rx_byte[6:0], i_data};
    end
    // eight 200 ns clocks, data after each fall, clock idle high
    task automatic send_frame(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_sck_oe = 1'b1;
            #20 frame_oe = ~b[i];
            #80 o_sck_oe = 1'b0;
            #100;
        end
        frame_oe = 1'b0;
    endtask : send_frame
endmodule : tws_far_model

// ### bench/test_tws_channel.sv
/* Self-checking bench of the two-wire serial channel.
 * Assumes pull-ups on all wires and the far model on the bus. */
module test_tws_channel;
    import tws_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk, i_srst, i_wr, i_rd, jam, sel_b;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rx;
    logic sck_oe, a_oe, b_oe, done, far_sck_oe, far_d_oe;
    logic sck_w, da_w, db_w;
    logic [2:0] outs;
    int error_cnt = 0;
    int total_checks = 0;
    // ------------------------------------------------------------
    // wires, device and far side
    // ------------------------------------------------------------
    assign sck_w = !(sck_oe | far_sck_oe);
    assign da_w = !(a_oe | far_d_oe);
    assign db_w = !(b_oe | far_d_oe);
    tws_channel #(.HALF_CYC(8)) u_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sck(sck_w), .o_sck_out(outs[0]), .o_sck_oe(sck_oe), .i_data_bus_a(da_w), .o_data_bus_a_out(outs[1]),
        .o_data_bus_a_oe(a_oe), .i_data_bus_b(db_w), .o_data_bus_b_out(outs[2]), .o_data_bus_b_oe(b_oe),
        .o_transfer_done(done));
    tws_far_model u_far (.i_sck(sck_w), .i_data(sel_b ? db_w : da_w), .i_jam(jam),
        .o_sck_oe(far_sck_oe), .o_data_oe(far_d_oe), .o_rx_byte(rx));
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rchk
    task automatic wait_done;
        for (int n = 0; n < 3000; n++) begin
            if (done === 1'b1) break;
            @(posedge i_ref_clk);
        end
    endtask : wait_done
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        wr(3'h7, 8'hFF);
        rchk(3'h7, 8'h00);
        rchk(OFS_MODE, 8'h00);
        rchk(OFS_TIMING, 8'h00);
        rchk(OFS_PORTS, 8'h01);
        rchk(OFS_STATUS, 8'h00);
        chk({5'h00, outs}, 8'h00);
        $display("reset test finished");
    endtask : t_reset
    task automatic t_triggers;
        wr(OFS_MODE, 8'h98); // wakeup kept 0
        wr(OFS_BUSCTL, 8'h02);
        repeat (2) @(posedge i_ref_clk);
        chk({7'h00, a_oe}, 8'h01);
        rchk(OFS_BUSCTL, 8'h00);
        wr(OFS_BUSCTL, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        chk({7'h00, a_oe}, 8'h00);
        $display("trigger test finished");
    endtask : t_triggers
    task automatic t_clock_latch;
        wr(OFS_MODE, 8'h1A); // mode changed while disabled
        wr(OFS_MODE, 8'h9A); // clock idle high first
        wr(OFS_PORTS, 8'h00);
        repeat (6) @(posedge i_ref_clk);
        chk({7'h00, sck_oe}, 8'h01);
        rchk(OFS_TIMING, 8'h00);
        wr(OFS_PORTS, 8'h01);
        repeat (6) @(posedge i_ref_clk);
        chk({7'h00, sck_oe}, 8'h00);
        rchk(OFS_TIMING, 8'h40);
        $display("clock latch test finished");
    endtask : t_clock_latch
    task automatic t_transmit;
        wr(OFS_SLAVE, 8'hA5);
        wr(OFS_SHIFT, 8'hA5);
        wait_done;
        chk(rx, 8'hA5);
        chk({7'h00, done}, 8'h01);
        rchk(OFS_SHIFT, 8'hA5);
        rchk(OFS_MODE, 8'hDA);
        rchk(OFS_STATUS, 8'h01);
        wr(OFS_STATUS, 8'h01);
        @(posedge i_ref_clk) jam <= 1'b1;
        wr(OFS_SHIFT, 8'hA5);
        wait_done;
        jam <= 1'b0;
        rchk(OFS_SHIFT, 8'h00);
        rchk(OFS_MODE, 8'h9A);
        wr(OFS_STATUS, 8'h01);
        $display("transmit test finished");
    endtask : t_transmit
    task automatic t_receive;
        wr(OFS_MODE, 8'h1C);
        wr(OFS_MODE, 8'h9C);
        sel_b <= 1'b1;
        wr(OFS_SHIFT, 8'hFF); // released for reception
        u_far.send_frame(8'h3C);
        wait_done;
        chk({7'h00, done}, 8'h01);
        rchk(OFS_SHIFT, 8'h3C);
        chk({7'h00, b_oe}, 8'h00);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_TIMING, 8'h20); // low bits written 0
        @(posedge i_ref_clk) jam <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        chk({7'h00, done}, 8'h00);
        jam <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        chk({7'h00, done}, 8'h01);
        wr(OFS_TIMING, 8'h00);
        wr(OFS_STATUS, 8'h01);
        $display("receive test finished");
    endtask : t_receive
    task automatic t_late_enable;
        wr(OFS_MODE, 8'h1C);
        rchk(OFS_TIMING, 8'h00);
        wr(OFS_SHIFT, 8'h55);
        wr(OFS_MODE, 8'h9C);
        repeat (100) @(posedge i_ref_clk);
        rchk(OFS_STATUS, 8'h00);
        $display("late enable test finished");
    endtask : t_late_enable
    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        jam = 1'b0;
        sel_b = 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        t_reset;
        t_triggers;
        t_clock_latch;
        t_transmit;
        t_receive;
        t_late_enable;
        wrap_up;
    end
    initial begin
        #2000000;
        error_cnt++;
        wrap_up;
    end
endmodule : test_tws_channel
